// ===== hw/pio_host_pkg.sv
// shared constants and carrier types for the task-file pio host
package pio_host_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NUM_MODES = 5;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 16;
    localparam int CNT_W = 8;
    // per-mode figures in ns: cycle, addr setup, strobe, recovery
    localparam int T_CYCLE_NS [NUM_MODES] = '{600, 383, 240, 180, 120};
    localparam int T_ASU_NS [NUM_MODES] = '{70, 50, 30, 30, 25};
    localparam int T_STB_NS [NUM_MODES] = '{165, 125, 100, 80, 70};
    localparam int T_STB8_NS [NUM_MODES] = '{290, 290, 290, 80, 70};
    localparam int T_REC_NS [NUM_MODES] = '{22, 22, 22, 70, 25};
    localparam int T_WDH_NS [NUM_MODES] = '{30, 20, 15, 10, 10};
    localparam int T_AH_NS [NUM_MODES] = '{20, 15, 10, 10, 10};
    localparam int READY_SAMPLE_DELAY_NS = 35;
    localparam int READY_WAIT_MAX_NS = 1250;
    // least times round up to whole cycles, never below one
    function automatic logic [CNT_W-1:0] ns2cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return CNT_W'(c);
    endfunction
    localparam logic [CNT_W-1:0] READY_SAMPLE_CYC =
        ns2cyc(READY_SAMPLE_DELAY_NS);
    // two extra cycles cover the two-flop ready synchroniser
    localparam logic [CNT_W-1:0] READY_WAIT_MAX_CYC =
        CNT_W'(READY_WAIT_MAX_NS / CLK_PERIOD_NS + 2);
    localparam logic [2:0] MODE_RESET = 3'h0;

    typedef struct packed {
        logic write;
        logic word;
        logic cs1;
        logic [2:0] addr;
        logic [2:0] mode;
    } pio_req_t;

    typedef struct packed {
        logic [15:0] data;
        logic is16;
        logic timeout;
    } pio_rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_WAIT, ST_HOLD, ST_RECOVER
    } pio_state_t;
endpackage

// ===== hw/pio_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
module pio_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } fifo_state_t;
    fifo_state_t st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full, empty, push, pop;

    assign empty = (st.wptr == st.rptr);
    assign full = (st.wptr[AW-1:0] == st.rptr[AW-1:0]) &&
                  (st.wptr[AW] != st.rptr[AW]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[st.rptr[AW-1:0]];
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wptr = st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = st.rptr + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // storage holds no reset: contents are meaningless until written
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[st.wptr[AW-1:0]] <= in_data_i;
        end
    end
endmodule

// ===== hw/pio_host.sv
// host controller driving pio task-file cycles with ready wait states
//
// Behaviour
// - location is chosen by two low-active chip selects and three address bits.
// - word accesses use sixteen data lines, byte accesses only the low eight.
// - the 16-bit indication counts only in modes 0 to 2, ignored above.
// - ready is sampled 40 ns (35 ns rounded up to whole cycles) after the strobe goes active.
// - ready never low means the cycle ends on normal mode timing.
// - ready low but back high before sampling adds no wait.
// - ready low at sampling holds the strobe until ready returns or the wait limit runs out, which flags a timeout.
`timescale 1ns/1ns
module pio_host (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire pio_host_pkg::pio_req_t req_i,
    input wire logic [15:0] wdata_i,
    output logic rsp_valid_o,
    input wire logic rsp_ready_i,
    output pio_host_pkg::pio_rsp_t rsp_o,
    output logic cs0_n_o,
    output logic cs1_n_o,
    output logic [2:0] addr_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [15:0] data_o,
    output logic data_oe_o,
    input wire logic [15:0] data_i,
    input wire logic ready_i,
    input wire logic is16_n_i
);
    localparam int RW = $bits(pio_host_pkg::pio_rsp_t);

    typedef struct packed {
        pio_host_pkg::pio_state_t fsm;
        pio_host_pkg::pio_req_t req;
        logic [15:0] wdata;
        logic [pio_host_pkg::CNT_W-1:0] cnt;
        logic [pio_host_pkg::CNT_W-1:0] total;
        logic [pio_host_pkg::CNT_W-1:0] wcnt;
        logic cs0_n;
        logic cs1_n;
        logic [2:0] addr;
        logic rd_n;
        logic wr_n;
        logic oe;
        logic [15:0] rdata;
        logic is16;
        logic timeout;
        logic push;
        logic [1:0] rdy_sync;
        logic [1:0] is16_sync;
        logic [1:0][15:0] din_sync;
    } host_state_t;
    host_state_t st, next_st;

    logic fifo_in_ready;
    logic [RW-1:0] fifo_out;
    pio_host_pkg::pio_rsp_t push_rsp;
    logic rdy;
    logic [2:0] m;

    assign rdy = st.rdy_sync[1];
    assign m = st.req.mode;
    assign push_rsp = '{data: st.rdata, is16: st.is16,
                        timeout: st.timeout};

    // rounding per mode, evaluated on the held mode
    function automatic logic [pio_host_pkg::CNT_W-1:0] cyc_of(
        input int ns);
        return pio_host_pkg::ns2cyc(ns);
    endfunction

    logic [pio_host_pkg::CNT_W-1:0] t_asu, t_stb, t_rec, t_hold, t_cyc;
    always_comb begin
        t_asu = '0;
        t_stb = '0;
        t_rec = '0;
        t_hold = '0;
        t_cyc = '0;
        for (int i = 0; i < pio_host_pkg::NUM_MODES; i++) begin
            if (m == 3'(i)) begin
                t_asu = cyc_of(pio_host_pkg::T_ASU_NS[i]);
                t_stb = st.req.word ?
                    cyc_of(pio_host_pkg::T_STB_NS[i]) :
                    cyc_of(pio_host_pkg::T_STB8_NS[i]);
                t_rec = cyc_of(pio_host_pkg::T_REC_NS[i]);
                t_hold = cyc_of(pio_host_pkg::T_WDH_NS[i] >
                    pio_host_pkg::T_AH_NS[i] ?
                    pio_host_pkg::T_WDH_NS[i] :
                    pio_host_pkg::T_AH_NS[i]);
                t_cyc = cyc_of(pio_host_pkg::T_CYCLE_NS[i]);
            end
        end
    end

    // accept only when the response fifo can take the result; a push
    // still in flight counts, or a result could meet a full fifo
    assign req_ready_o = (st.fsm == pio_host_pkg::ST_IDLE) &&
                         fifo_in_ready && !st.push;

    always_comb begin
        next_st = st;
        next_st.push = 1'b0;
        next_st.rdy_sync = {st.rdy_sync[0], ready_i};
        next_st.is16_sync = {st.is16_sync[0], !is16_n_i};
        next_st.din_sync = {st.din_sync[0], data_i};
        if (st.fsm != pio_host_pkg::ST_IDLE) begin
            next_st.total = st.total + 1'b1;
        end
        unique case (st.fsm)
            pio_host_pkg::ST_IDLE: begin
                if (req_valid_i && req_ready_o) begin
                    next_st.req = req_i;
                    if (req_i.mode >= 3'(pio_host_pkg::NUM_MODES)) begin
                        next_st.req.mode = pio_host_pkg::MODE_RESET;
                    end
                    next_st.wdata = req_i.word ? wdata_i :
                        {8'h00, wdata_i[7:0]};
                    next_st.cs0_n = req_i.cs1;
                    next_st.cs1_n = !req_i.cs1;
                    next_st.addr = req_i.addr;
                    next_st.oe = req_i.write;
                    next_st.cnt = '0;
                    next_st.total = '0;
                    next_st.timeout = 1'b0;
                    next_st.fsm = pio_host_pkg::ST_SETUP;
                end
            end
            pio_host_pkg::ST_SETUP: begin
                next_st.cnt = st.cnt + 1'b1;
                if (st.cnt + 1'b1 >= t_asu) begin
                    next_st.cnt = '0;
                    next_st.rd_n = st.req.write;
                    next_st.wr_n = !st.req.write;
                    next_st.fsm = pio_host_pkg::ST_STROBE;
                end
            end
            pio_host_pkg::ST_STROBE: begin
                next_st.cnt = st.cnt + 1'b1;
                // synchronised ready seen at the sample point decides
                if (st.cnt + 1'b1 == pio_host_pkg::READY_SAMPLE_CYC + 2'd2
                    && !rdy) begin
                    next_st.wcnt = '0;
                    next_st.fsm = pio_host_pkg::ST_WAIT;
                end else if (st.cnt + 1'b1 >= t_stb &&
                    st.cnt + 1'b1 > pio_host_pkg::READY_SAMPLE_CYC +
                    2'd2) begin
                    next_st.cnt = '0;
                    next_st.fsm = pio_host_pkg::ST_HOLD;
                end
            end
            pio_host_pkg::ST_WAIT: begin
                next_st.wcnt = st.wcnt + 1'b1;
                // data sampled with ready returning is valid then
                if (rdy) begin
                    next_st.cnt = '0;
                    next_st.fsm = pio_host_pkg::ST_HOLD;
                end else if (st.wcnt >= pio_host_pkg::READY_WAIT_MAX_CYC)
                begin
                    next_st.timeout = 1'b1;
                    next_st.cnt = '0;
                    next_st.fsm = pio_host_pkg::ST_HOLD;
                end
            end
            pio_host_pkg::ST_HOLD: begin
                if (st.cnt == '0) begin
                    next_st.rd_n = 1'b1;
                    next_st.wr_n = 1'b1;
                    next_st.rdata = st.req.word ? st.din_sync[1] :
                        {8'h00, st.din_sync[1][7:0]};
                    // 16-bit flag is meaningless above mode 2
                    next_st.is16 = (m <= 3'h2) &&
                        st.is16_sync[1];
                end
                next_st.cnt = st.cnt + 1'b1;
                // selects and write data stay t_hold cycles past the strobe
                if (st.cnt >= t_hold) begin
                    next_st.cnt = '0;
                    next_st.oe = 1'b0;
                    next_st.cs0_n = 1'b1;
                    next_st.cs1_n = 1'b1;
                    next_st.fsm = pio_host_pkg::ST_RECOVER;
                end
            end
            pio_host_pkg::ST_RECOVER: begin
                next_st.cnt = st.cnt + 1'b1;
                if (st.cnt + 1'b1 >= t_rec && st.total + 1'b1 >= t_cyc)
                begin
                    next_st.push = 1'b1;
                    next_st.fsm = pio_host_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
            st.fsm <= pio_host_pkg::ST_IDLE;
            st.cs0_n <= 1'b1;
            st.cs1_n <= 1'b1;
            st.rd_n <= 1'b1;
            st.wr_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign cs0_n_o = st.cs0_n;
    assign cs1_n_o = st.cs1_n;
    assign addr_o = st.addr;
    assign rd_n_o = st.rd_n;
    assign wr_n_o = st.wr_n;
    assign data_o = st.wdata;
    assign data_oe_o = st.oe;
    assign rsp_o = pio_host_pkg::pio_rsp_t'(fifo_out);

    pio_fifo #(
        .WIDTH(RW),
        .DEPTH(pio_host_pkg::FIFO_DEPTH)
    ) u_rsp_fifo (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .in_valid_i(st.push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(RW'(push_rsp)),
        .out_valid_o(rsp_valid_o),
        .out_ready_i(rsp_ready_i),
        .out_data_o(fifo_out)
    );
endmodule

// ===== sim/pio_host_monitor.sv
// assertions on the pio host pins and response side
`timescale 1ns/1ns
module pio_host_monitor (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic cs0_n_o,
    input wire logic cs1_n_o,
    input wire logic [2:0] addr_o,
    input wire logic rd_n_o,
    input wire logic wr_n_o,
    input wire logic data_oe_o,
    input wire logic ready_i
);
    // ========================================
    // strobe bookkeeping
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic stb;
    logic [7:0] low_cnt;
    assign stb = !rd_n_o || !wr_n_o;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_cnt <= 8'h0;
        end else begin
            low_cnt <= stb ? low_cnt + 8'h1 : 8'h0;
        end
    end
    property p_sel; stb |-> !(cs0_n_o && cs1_n_o); endproperty
    a_sel: assert property (p_sel) else $error("strobe unselected");
    property p_hold; stb && $past(stb) |-> $stable(addr_o); endproperty
    a_hold: assert property (p_hold) else $error("addr moved");
    property p_wr; !wr_n_o |-> data_oe_o; endproperty
    a_wr: assert property (p_wr) else $error("write undriven");
    property p_setup; $rose(stb) |-> $past(!(cs0_n_o && cs1_n_o), 2);
    endproperty
    a_setup: assert property (p_setup) else $error("no setup");
    property p_min; $rose(stb) |-> stb [*7]; endproperty
    a_min: assert property (p_min) else $error("strobe short");
    // guard leaves room for the forced end of an overlong wait
    property p_wait; (stb && !ready_i) [*4] ##0 (low_cnt < 8'h64) |=> stb;
    endproperty
    a_wait: assert property (p_wait) else $error("wait cut");
    property p_bound; low_cnt <= 8'hc8; endproperty
    a_bound: assert property (p_bound) else $error("wait endless");
    property p_end; $rose(rsp_valid_o) |-> cs0_n_o && cs1_n_o && !stb;
    endproperty
    a_end: assert property (p_end) else $error("early answer");
    property p_ahold; $fell(stb) |-> !(cs0_n_o && cs1_n_o); endproperty
    a_ahold: assert property (p_ahold) else $error("cs hold");
    property p_dhold; $fell(stb) && $past(!wr_n_o) |-> data_oe_o;
    endproperty
    a_dhold: assert property (p_dhold) else $error("data hold");
    c_wait: cover property ((stb && !ready_i) [*8]);
    c_rsp: cover property ($rose(rsp_valid_o));
    c_full: cover property (rsp_valid_o && !req_ready_o && !stb);
endmodule

bind pio_host pio_host_monitor u_mon (.mclk_i, .rstn_i, .req_ready_o,
    .rsp_valid_o, .cs0_n_o, .cs1_n_o, .addr_o, .rd_n_o, .wr_n_o,
    .data_oe_o, .ready_i);

// ===== sim/pio_card_model.sv
// card-side model answering task-file cycles
`timescale 1ns/1ns
module pio_card_model (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic cs0_n_i,
    input wire logic cs1_n_i,
    input wire logic [2:0] addr_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [15:0] wdata_i,
    input wire logic [31:0] wait_i,
    output logic [15:0] data_o,
    output logic ready_o,
    output logic is16_n_o,
    output logic [15:0] wr_seen_o,
    output logic [3:0] loc_seen_o
);
    // ========================================
    // card behaviour
    logic stb;
    logic stb_q;
    int cnt;
    logic [15:0] last;
    logic [15:0] pat;
    assign stb = !rd_n_i || !wr_n_i;
    assign pat = 16'h5a00 | {12'h0, !cs1_n_i, addr_i};
    assign ready_o = (cnt == 0);
    assign is16_n_o = !(!cs0_n_i && addr_i == 3'h0);
    // garbage until ready returns, flips each cycle when released
    assign data_o = (!rd_n_i && ready_o) ? pat : ~last;
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 0;
            stb_q <= 1'b0;
            last <= 16'h0;
        end else begin
            stb_q <= stb;
            last <= data_o;
            // only a bench-ordered wait runs past the limit
            if (stb && !stb_q) begin
                cnt <= int'(wait_i);
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
            if (!wr_n_i) begin
                wr_seen_o <= wdata_i;
                loc_seen_o <= {!cs1_n_i, addr_i};
            end
        end
    end
endmodule

// ===== sim/pio_host_bench.sv
// self-checking bench for the pio task-file host
`timescale 1ns/1ns
module pio_host_bench;
    logic mclk_i = 0;
    logic rstn_i = 0;
    logic req_valid_i = 0;
    pio_host_pkg::pio_req_t req_i = '0;
    logic [15:0] wdata_i = 16'h0;
    logic rsp_ready_i = 0;
    int wait_cyc = 0;
    logic req_ready_o, rsp_valid_o, cs0_n_o, cs1_n_o, rd_n_o, wr_n_o;
    logic data_oe_o, ready_i, is16_n_i;
    logic [2:0] addr_o;
    logic [15:0] data_o, data_i, wr_seen;
    logic [3:0] loc_seen;
    pio_host_pkg::pio_rsp_t rsp_o;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int run = 0;
    int last_len = 0;
    int len0;
    logic [31:0] rnd = 32'hc5ec;
    always #5 mclk_i = ~mclk_i;
    pio_host uut (.mclk_i, .rstn_i, .req_valid_i, .req_ready_o, .req_i,
        .wdata_i, .rsp_valid_o, .rsp_ready_i, .rsp_o, .cs0_n_o, .cs1_n_o,
        .addr_o, .rd_n_o, .wr_n_o, .data_o, .data_oe_o, .data_i, .ready_i,
        .is16_n_i);
    pio_card_model card (.mclk_i, .rstn_i, .cs0_n_i(cs0_n_o),
        .cs1_n_i(cs1_n_o), .addr_i(addr_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
        .wdata_i(data_o), .wait_i(wait_cyc), .data_o(data_i),
        .ready_o(ready_i), .is16_n_o(is16_n_i), .wr_seen_o(wr_seen),
        .loc_seen_o(loc_seen));
    // ========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] exp_rd(input logic c, logic [2:0] a,
        input logic wd);
        logic [15:0] v;
        v = 16'h5a00 | {12'h0, c, a};
        return wd ? v : {8'h0, v[7:0]};
    endfunction
    task automatic chk(input string what, input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic issue(input logic w, wd, c, input logic [2:0] a, m,
        input logic [15:0] d, input int wt);
        @(negedge mclk_i);
        wait_cyc = wt;
        req_i = '{w, wd, c, a, m};
        wdata_i = d;
        req_valid_i = 1;
        do @(posedge mclk_i); while (req_ready_o !== 1'b1);
        @(negedge mclk_i);
        req_valid_i = 0;
    endtask
    task automatic take(input logic [15:0] ed, input logic e16, to, rd);
        for (int n = 0; n < 400 && rsp_valid_o !== 1'b1; n++) begin
            @(negedge mclk_i);
        end
        chk("rsp_valid", 16'(rsp_valid_o), 16'h1);
        if (rd) chk("rdata", rsp_o.data, ed);
        chk("is16", 16'(rsp_o.is16), 16'(e16));
        chk("timeout", 16'(rsp_o.timeout), 16'(to));
        rsp_ready_i = 1;
        @(negedge mclk_i);
        rsp_ready_i = 0;
    endtask
    task automatic op(input logic w, wd, c, input logic [2:0] a, m,
        input logic [15:0] d, input int wt, input logic to);
        issue(w, wd, c, a, m, d, wt);
        // modes above 4 run as mode 0; read data is void after a timeout
        take(exp_rd(c, a, wd), (m <= 2 || m > 4) && !c && a == 0, to,
            !w && !to);
        if (w) begin
            chk("wdata", wd ? wr_seen : {8'h0, wr_seen[7:0]},
                wd ? d : {8'h0, d[7:0]});
            chk("loc", 16'(loc_seen), 16'({c, a}));
        end
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (!rd_n_o || !wr_n_o) begin
            run++;
        end else if (run != 0) begin
            last_len = run;
            run = 0;
        end
        if (cyc == 12000) begin
            num_errors++;
            wrap_up;
        end
    end
    // ========================================
    // scenarios
    initial begin
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i);
        rstn_i = 1;
        for (int m = 0; m < 5; m++) op(0, 1, 0, 3'h0, 3'(m), 0, 0, 0);
        op(0, 1, 0, 3'h0, 3'h7, 16'h0, 0, 0);
        op(1, 0, 1, 3'h6, 3'h0, 16'hbeef, 0, 0);
        op(0, 1, 0, 3'h2, 3'h4, 16'h0, 0, 0);
        len0 = last_len;
        op(0, 1, 0, 3'h2, 3'h4, 16'h0, 2, 0);
        chk("short_dip", 16'(last_len), 16'(len0));
        op(1, 1, 0, 3'h1, 3'h4, 16'h1234, 30, 0);
        chk("stretch", 16'(last_len > len0 + 20), 16'h1);
        op(0, 1, 1, 3'h5, 3'h4, 16'h0, 30, 0);
        op(0, 1, 0, 3'h3, 3'h4, 16'h0, 200, 1);
        repeat (100) @(negedge mclk_i);
        for (int i = 0; i < 16; i++) issue(0, 1, 0, 3'(i), 3'h4, 0, 0);
        repeat (40) @(negedge mclk_i);
        chk("full", 16'(req_ready_o), 16'h0);
        for (int i = 0; i < 16; i++) take(exp_rd(0, 3'(i), 1), 0, 0, 1);
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            op(rnd[0], rnd[1], rnd[2], rnd[5:3], 3'(rnd[10:8] % 5),
                rnd[31:16], 0, 0);
        end
        wrap_up;
    end
endmodule
